// *** rtl/lpcal_pkg.sv ***
/*
 * lpcal_pkg: register map, field positions, reset values and timing
 * constants for the low-power oscillator calibration block.
 * Assumes a 32-bit classic Wishbone register bus and a 50 MHz system clock.
 */
package lpcal_pkg;

	// register byte addresses
	localparam logic [31:0] LPCAL_ADR_TRIM     = 32'hffff_042c;
	localparam logic [31:0] LPCAL_ADR_CONTROL  = 32'hffff_0440;
	localparam logic [31:0] LPCAL_ADR_STATUS   = 32'hffff_0444;
	localparam logic [31:0] LPCAL_ADR_REF_CNT  = 32'hffff_0448;
	localparam logic [31:0] LPCAL_ADR_LP_CNT   = 32'hffff_044c;
	localparam logic [31:0] LPCAL_ADR_IRQ_STAT = 32'hffff_0450;
	localparam logic [31:0] LPCAL_ADR_IRQ_MASK = 32'hffff_0454;

	// cal_control fields
	localparam int LPCAL_CTL_ENABLE  = 0;
	localparam int LPCAL_CTL_CLR_REF = 1;
	localparam int LPCAL_CTL_CLR_LP  = 2;
	localparam int LPCAL_CTL_RESET   = 3;
	localparam int LPCAL_CTL_SRC     = 4;

	// cal_status fields
	localparam int LPCAL_STA_BUSY = 0;
	localparam int LPCAL_STA_DONE = 1;

	// interrupt status / mask fields
	localparam int LPCAL_IRQ_DONE    = 0;
	localparam int LPCAL_IRQ_TIMEOUT = 1;
	localparam int LPCAL_IRQ_W       = 2;

	// widths and values
	localparam int          LPCAL_REF_W     = 9;
	localparam int          LPCAL_LP_W      = 10;
	localparam int          LPCAL_TRIM_W    = 4;
	localparam logic [8:0]  LPCAL_REF_TERM  = 9'h1ff;
	localparam logic [1:0]  LPCAL_DIV_LAST  = 2'h3;
	localparam logic [3:0]  LPCAL_TRIM_RST  = 4'h8;
	localparam logic [7:0]  LPCAL_CTL_RST   = 8'h00;

	// timing
	localparam int LPCAL_CLK_HZ       = 50_000_000;
	localparam int LPCAL_PREC_TIME_MS = 4;
	localparam int LPCAL_XTAL_TIME_MS = 16;
	localparam int LPCAL_PREC_CYC     = LPCAL_PREC_TIME_MS * (LPCAL_CLK_HZ / 1000);
	localparam int LPCAL_XTAL_CYC     = LPCAL_XTAL_TIME_MS * (LPCAL_CLK_HZ / 1000);
	localparam int LPCAL_TIMEOUT_CYC  = 2 * LPCAL_XTAL_CYC;
	localparam int LPCAL_TMO_W        = 22;

endpackage

// *** rtl/lpcal_pin_sync.sv ***
/*
 * lpcal_pin_sync: two-flop synchroniser for an oscillator pin followed by a
 * rising-edge detector working on the synchronised level only.
 * Assumes the pin toggles well below half the system clock rate.
 */
`timescale 1ns/100ps
module lpcal_pin_sync
(
	// clock, reset, enable
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_clk_en,
	// pin in, edge out
	input  wire logic i_pin,
	output logic      o_rise
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	// first stage is read by the second stage only
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else if (i_clk_en)
		begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// edge pulse, gated so a frozen block sees no phantom edges
	assign o_rise = i_clk_en & sync_r & ~last_r;

endmodule

// *** rtl/lpcal_counter.sv ***
/*
 * lpcal_counter: up counter with synchronous clear; clear wins over count.
 * Assumes the increment is a one-cycle pulse on the system clock.
 */
`timescale 1ns/100ps
module lpcal_counter
#(
	parameter int W = 9
)
(
	// clock, reset, enable
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_clk_en,
	// control
	input  wire logic         i_clr,
	input  wire logic         i_inc,
	// count
	output logic [W-1:0]      o_count
);

	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	// clear first so a start never inherits an old count
	assign count_nxt = i_clr ? '0 : (i_inc ? W'(count_r + 1'b1) : count_r);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			count_r <= '0;
		else if (i_clk_en)
			count_r <= count_nxt;
	end

	assign o_count = count_r;

endmodule

// *** rtl/lpcal_top.sv ***
/*
 * lpcal_top: calibration logic for the low-power oscillator, with a classic
 * Wishbone register slave, sticky interrupt status and a trim output.
 * Assumes the three oscillator signals arrive as asynchronous pins, each far
 * slower than the 50 MHz system clock; the oscillators sit outside.
 */
// The implementer's own choice: the Wishbone slave port.
// How it works
// RQ1: nine-bit reference counter on selected accurate source
// RQ2: ten-bit counter on low-power clock, optionally divided
// RQ3: software keeps both count clocks equal nominal
// RQ4: trim is four bits, upper bits zero
// RQ5: higher trim code slows the oscillator
// RQ6: reference terminal count stops and holds both
// RQ7: software compares counts and steps trim
// RQ8: software reruns calibration after trim change
// RQ9: software moves PLL source before calibrating
// RQ10: control bit four picks crystal or precision
// RQ11: control bit three resets counters, stops calibration
// RQ12: bits two and one clear counters
// RQ13: bit zero starts, clearing it aborts
// RQ14: done flag set on finish, cleared reading
// RQ15: busy flag shows calibration in progress
// RQ16: cycle takes about 4 or 16 ms
// RQ17: counters start together from zero, zero-extended reads
`timescale 1ns/100ps
module lpcal_top
	import lpcal_pkg::*;
#(
	parameter int TIMEOUT_CYC = LPCAL_TIMEOUT_CYC
)
(
	// clock, reset, enable
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	// oscillator pins
	input  wire logic        i_prec_osc,
	input  wire logic        i_xtal_osc,
	input  wire logic        i_lp_osc,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [31:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// oscillator trim and interrupt
	output logic [3:0]       o_lp_trim,
	output logic             o_irq
);

	// bus access decode: one access per request, answered next cycle
	logic ack_r;
	logic acc;
	logic wr;
	logic rd;
	logic wr_b0;
	logic sel_trim;
	logic sel_ctl;
	logic sel_sta;
	logic sel_ref;
	logic sel_lp;
	logic sel_ist;
	logic sel_imk;
	assign acc      = i_wb_cyc & i_wb_stb & ~ack_r;
	assign wr       = acc & i_wb_we;
	assign rd       = acc & ~i_wb_we;
	assign wr_b0    = wr & i_wb_sel[0];
	assign sel_trim = (i_wb_adr == LPCAL_ADR_TRIM);
	assign sel_ctl  = (i_wb_adr == LPCAL_ADR_CONTROL);
	assign sel_sta  = (i_wb_adr == LPCAL_ADR_STATUS);
	assign sel_ref  = (i_wb_adr == LPCAL_ADR_REF_CNT);
	assign sel_lp   = (i_wb_adr == LPCAL_ADR_LP_CNT);
	assign sel_ist  = (i_wb_adr == LPCAL_ADR_IRQ_STAT);
	assign sel_imk  = (i_wb_adr == LPCAL_ADR_IRQ_MASK);

	// control writes; bits 3..1 are actions, not stored
	logic ctl_wr;
	logic cmd_reset;
	logic cmd_clr_ref;
	logic cmd_clr_lp;
	logic cmd_start;
	logic cmd_stop;
	assign ctl_wr      = wr_b0 & sel_ctl;
	assign cmd_reset   = ctl_wr & i_wb_dat[LPCAL_CTL_RESET];   // RQ11
	assign cmd_clr_ref = ctl_wr & i_wb_dat[LPCAL_CTL_CLR_REF]; // RQ12
	assign cmd_clr_lp  = ctl_wr & i_wb_dat[LPCAL_CTL_CLR_LP];  // RQ12
	assign cmd_start   = ctl_wr & i_wb_dat[LPCAL_CTL_ENABLE] & ~cmd_reset; // RQ13
	assign cmd_stop    = ctl_wr & ~i_wb_dat[LPCAL_CTL_ENABLE];

	// stored state
	logic       enable_r;
	logic       src_xtal_r;
	logic       running_r;
	logic       done_r;
	logic [3:0] trim_r;
	logic [1:0] lp_div_r;
	logic [LPCAL_IRQ_W-1:0] irq_stat_r;
	logic [LPCAL_IRQ_W-1:0] irq_mask_r;
	logic [LPCAL_TMO_W-1:0] tmo_r;
	logic [31:0] rdat_r;

	// oscillator edges, each through its own synchroniser
	logic prec_rise;
	logic xtal_rise;
	logic lp_rise;
	lpcal_pin_sync u_sync_prec
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_prec_osc),
		.o_rise    (prec_rise)
	);
	lpcal_pin_sync u_sync_xtal
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_xtal_osc),
		.o_rise    (xtal_rise)
	);
	lpcal_pin_sync u_sync_lp
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_lp_osc),
		.o_rise    (lp_rise)
	);

	// count enables: reference follows source select, lp divided for crystal
	logic ref_edge;
	logic lp_edge;
	logic ref_inc;
	logic lp_inc;
	assign ref_edge = src_xtal_r ? xtal_rise : prec_rise;                 // RQ10
	assign lp_edge  = src_xtal_r ? (lp_rise & (lp_div_r == LPCAL_DIV_LAST)) : lp_rise; // RQ2
	assign ref_inc  = running_r & ref_edge;                               // RQ1
	assign lp_inc   = running_r & lp_edge;                                // RQ2

	// counters clear together on start, so both begin on the same edge
	logic [LPCAL_REF_W-1:0] ref_cnt;
	logic [LPCAL_LP_W-1:0]  lp_cnt;
	logic ref_clr;
	logic lp_clr;
	assign ref_clr = cmd_start | cmd_reset | cmd_clr_ref; // RQ17
	assign lp_clr  = cmd_start | cmd_reset | cmd_clr_lp;  // RQ17
	lpcal_counter #(.W(LPCAL_REF_W)) u_ref_cnt
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_clr     (ref_clr),
		.i_inc     (ref_inc),
		.o_count   (ref_cnt)
	);
	lpcal_counter #(.W(LPCAL_LP_W)) u_lp_cnt
	(
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_clr     (lp_clr),
		.i_inc     (lp_inc),
		.o_count   (lp_cnt)
	);

	// finish on the terminal count; a control write in the same cycle wins,
	// so a restart or an abort is never undone by a stale finish
	logic finish;
	logic timeout;
	assign finish  = ref_inc & ~ctl_wr & (ref_cnt == LPCAL_REF_TERM - 9'h001); // RQ6
	assign timeout = running_r & ~ctl_wr & (tmo_r == LPCAL_TMO_W'(TIMEOUT_CYC - 1)); // RQ16

	// run state; a stalled reference oscillator is caught by the timeout
	logic running_nxt;
	assign running_nxt = (cmd_reset | cmd_stop | finish | timeout) ? 1'b0 : // RQ6 RQ11 RQ13
		(cmd_start ? 1'b1 : running_r);

	// done flag: set wins over the clearing read of lp_cal_count
	logic done_nxt;
	assign done_nxt = finish | (done_r & ~(rd & sel_lp) & ~cmd_start & ~cmd_reset); // RQ14

	// interrupt status: sticky, read clears, new events win
	logic [LPCAL_IRQ_W-1:0] irq_evt;
	logic [LPCAL_IRQ_W-1:0] irq_stat_nxt;
	assign irq_evt      = {timeout, finish};
	assign irq_stat_nxt = irq_evt | ((rd & sel_ist) ? '0 : irq_stat_r);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			enable_r   <= LPCAL_CTL_RST[LPCAL_CTL_ENABLE];
			src_xtal_r <= LPCAL_CTL_RST[LPCAL_CTL_SRC];
			running_r  <= 1'b0;
			done_r     <= 1'b0;
			irq_stat_r <= '0;
		end
		else if (i_clk_en)
		begin
			if (ctl_wr)
			begin
				enable_r   <= i_wb_dat[LPCAL_CTL_ENABLE] & ~cmd_reset; // RQ11
				src_xtal_r <= i_wb_dat[LPCAL_CTL_SRC];                 // RQ10
			end
			else if (finish | timeout)
				enable_r <= 1'b0;
			running_r  <= running_nxt;
			done_r     <= done_nxt;
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// trim, mask, crystal divider and watchdog
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			trim_r     <= LPCAL_TRIM_RST;
			irq_mask_r <= '0;
			lp_div_r   <= '0;
			tmo_r      <= '0;
		end
		else if (i_clk_en)
		begin
			if (wr_b0 & sel_trim)
				trim_r <= i_wb_dat[LPCAL_TRIM_W-1:0]; // RQ4
			if (wr_b0 & sel_imk)
				irq_mask_r <= i_wb_dat[LPCAL_IRQ_W-1:0];
			if (cmd_start)
				lp_div_r <= '0;
			else if (running_r & lp_rise)
				lp_div_r <= lp_div_r + 2'h1;
			tmo_r <= (running_r & ~cmd_start) ? LPCAL_TMO_W'(tmo_r + 1'b1) : '0;
		end
	end

	// read mux; narrow registers zero-extended, unmapped reads give zero
	logic [31:0] rmux;
	assign rmux =
		sel_trim ? {28'h000_0000, trim_r} :                               // RQ4
		sel_ctl  ? {27'h000_0000, src_xtal_r, 3'h0, enable_r} :
		sel_sta  ? {30'h0000_0000, done_r, running_r} :                  // RQ15
		sel_ref  ? {23'h00_0000, ref_cnt} :                               // RQ17
		sel_lp   ? {22'h00_0000, lp_cnt} :                                // RQ17
		sel_ist  ? {30'h0000_0000, irq_stat_r} :
		sel_imk  ? {30'h0000_0000, irq_mask_r} : 32'h0000_0000;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end
		else if (i_clk_en)
		begin
			ack_r <= acc;
			if (rd)
				rdat_r <= rmux;
		end
	end

	// trim code goes straight to the analog cell: larger code, slower clock
	assign o_lp_trim = trim_r; // RQ5
	assign o_wb_dat  = rdat_r;
	assign o_wb_ack  = ack_r;
	assign o_irq     = |(irq_stat_r & irq_mask_r);

	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n || !i_clk_en);

	sequence s_last_ref_tick;
		running_r && ref_inc && ref_cnt == 9'h1fe && !ctl_wr;
	endsequence
	sequence s_stopped_done;
		!running_r && done_r && ref_cnt == 9'h1ff;
	endsequence

	a_term_stops_run: // RQ6
	assert property (s_last_ref_tick |=> s_stopped_done)
		else $error("reference terminal count did not stop calibration");

	a_counts_held: // RQ6
	assert property (!running_r && !ctl_wr |=> $stable(ref_cnt) && $stable(lp_cnt))
		else $error("counts moved while calibration idle");

	a_reset_cmd: // RQ11
	assert property (cmd_reset |=> !running_r && ref_cnt == 9'h000 && lp_cnt == 10'h000)
		else $error("calibration reset did not clear and stop");

	a_clear_lp: // RQ12
	assert property (cmd_clr_lp |=> lp_cnt == 10'h000)
		else $error("lp count clear failed");

	a_clear_ref: // RQ12
	assert property (cmd_clr_ref |=> ref_cnt == 9'h000)
		else $error("reference count clear failed");

	a_start_run: // RQ13
	assert property (cmd_start |=> running_r && ref_cnt == 9'h000 && lp_cnt == 10'h000) // RQ17
		else $error("start did not begin a clean cycle");

	a_abort_run: // RQ13
	assert property (running_r && cmd_stop |=> !running_r && !done_r)
		else $error("abort did not stop calibration");

	a_done_clear: // RQ14
	assert property (done_r && rd && sel_lp && !finish |=> !done_r)
		else $error("lp count read did not clear done");

	a_busy_read: // RQ15
	assert property (rd && sel_sta |=> o_wb_ack && o_wb_dat[0] == $past(running_r))
		else $error("status busy bit wrong");

	a_trim_upper: // RQ4
	assert property (rd && sel_trim |=> o_wb_dat[31:4] == 28'h000_0000)
		else $error("trim upper bits not zero");

	a_xtal_divide: // RQ2
	assert property (running_r && src_xtal_r && lp_inc |-> lp_div_r == 2'h3)
		else $error("lp count advanced off the divided clock");

endmodule

// *** tb/tb_top.sv ***
/*
 * tb_top: register-level bench for lpcal_top, classic wishbone master tasks
 * plus oscillator pins made from the system clock.
 * Assumes lpcal_pkg addresses and a shortened timeout parameter.
 */
`timescale 1ns/100ps
module tb_top
	import lpcal_pkg::*;
;
	localparam int TMO = 20000;
	logic        clk, rst_n, clk_en, cyc, stb, we, ack, irq, xsel;
	logic        prec = 1'b0, xtal = 1'b0, lp = 1'b0;
	logic [31:0] adr, wdat, rdat, v, hold;
	logic [3:0]  sel, trim;
	int          err_total, n_tests, ref_hp, lp_hp;
	int          rc = 0, lc = 0;

	lpcal_top #(.TIMEOUT_CYC(TMO)) DUT (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
		.i_prec_osc(prec), .i_xtal_osc(xtal), .i_lp_osc(lp),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_lp_trim(trim), .o_irq(irq));

	// clock, 20 ns period
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// oscillator pins toggled on clock edges; ref_hp of 0 stops the reference
	always @(posedge clk)
	begin
		if (ref_hp != 0 && rc >= ref_hp - 1)
		begin
			rc <= 0;
			prec <= xsel ? 1'b0 : ~prec;
			xtal <= xsel ? ~xtal : 1'b0;
		end
		else
			rc <= rc + 1;
		if (lc >= lp_hp - 1)
		begin
			lc <= 0;
			lp <= ~lp;
		end
		else
			lc <= lc + 1;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic cycle: request held until ack is sampled high
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		r = rdat;
		if (n >= 50)
			chk("ack", 32'h0000_0000, 32'h0000_0001);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0000_0000, r);
		chk(name, r, e);
	endtask

	// poll busy with a bound; gives the wait a hard end
	task automatic wait_idle();
		logic [31:0] r;
		int n;
		n = 0;
		do
		begin
			wb(1'b0, LPCAL_ADR_STATUS, 32'h0000_0000, r);
			n++;
		end
		while (r[LPCAL_STA_BUSY] !== 1'b0 && n < 12000);
		chk("idle", {31'h0, r[LPCAL_STA_BUSY]}, 32'h0000_0000);
	endtask

	task automatic lp_range(input string name);
		wb(1'b0, LPCAL_ADR_LP_CNT, 32'h0000_0000, v);
		chk(name, {31'h0, v >= 32'd505 && v <= 32'd517}, 32'h0000_0001);
	endtask

	// watchdog sized for two calibrations, two partial runs and one timeout
	initial
	begin
		repeat (90000) @(posedge clk);
		err_total++;
		complete_run();
	end

	initial
	begin
		{cyc, stb, we, xsel} = 4'h0;
		clk_en = 1'b1;
		adr = 32'h0000_0000;
		wdat = 32'h0000_0000;
		sel = 4'h0;
		err_total = 0;
		n_tests = 0;
		{ref_hp, lp_hp} = {32'd16, 32'd16};
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and an unmapped place
		rd_chk("trim", LPCAL_ADR_TRIM, 32'h0000_0008);
		rd_chk("ctl", LPCAL_ADR_CONTROL, 32'h0000_0000);
		rd_chk("sta", LPCAL_ADR_STATUS, 32'h0000_0000);
		rd_chk("ref", LPCAL_ADR_REF_CNT, 32'h0000_0000);
		rd_chk("lpc", LPCAL_ADR_LP_CNT, 32'h0000_0000);
		rd_chk("unmapped", 32'hffff_0460, 32'h0000_0000);
		chk("irq", {31'h0, irq}, 32'h0000_0000);
		// trim code reaches the pin; a status write is ignored and status reads as zero
		wr(LPCAL_ADR_TRIM, 32'h0000_0007);
		rd_chk("trim", LPCAL_ADR_TRIM, 32'h0000_0007);
		chk("trim pin", {28'h0, trim}, 32'h0000_0007);
		wr(LPCAL_ADR_STATUS, 32'h0000_0003);
		rd_chk("sta ro", LPCAL_ADR_STATUS, 32'h0000_0000);
		// precision run, equal clocks, done interrupt unmasked
		wr(LPCAL_ADR_IRQ_MASK, 32'h0000_0001);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0001);
		rd_chk("sta busy", LPCAL_ADR_STATUS, 32'h0000_0001);
		wait_idle();
		rd_chk("ref end", LPCAL_ADR_REF_CNT, {23'h0, LPCAL_REF_TERM});
		rd_chk("ctl end", LPCAL_ADR_CONTROL, 32'h0000_0000);
		rd_chk("sta done", LPCAL_ADR_STATUS, 32'h0000_0002);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		lp_range("lpc prec");
		hold = v;
		rd_chk("sta clr", LPCAL_ADR_STATUS, 32'h0000_0000);
		rd_chk("lpc held", LPCAL_ADR_LP_CNT, hold);
		rd_chk("irq sta", LPCAL_ADR_IRQ_STAT, 32'h0000_0001);
		rd_chk("irq sta clr", LPCAL_ADR_IRQ_STAT, 32'h0000_0000);
		chk("irq off", {31'h0, irq}, 32'h0000_0000);
		// software steps trim: slow lp clock lowers the code, fast raises it
		v = (hold < 32'h0000_01ff) ? 32'h0000_0006 :
			((hold > 32'h0000_01ff) ? 32'h0000_0008 : 32'h0000_0007);
		wr(LPCAL_ADR_TRIM, v);
		rd_chk("trim step", LPCAL_ADR_TRIM, v);
		chk("trim step pin", {28'h0, trim}, v);
		// separate clears
		wr(LPCAL_ADR_CONTROL, 32'h0000_0002);
		rd_chk("ref clr", LPCAL_ADR_REF_CNT, 32'h0000_0000);
		rd_chk("lpc kept", LPCAL_ADR_LP_CNT, hold);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0004);
		rd_chk("lpc clr", LPCAL_ADR_LP_CNT, 32'h0000_0000);
		// crystal run with fast low-power clock through the divider, masked
		xsel <= 1'b1;
		lp_hp <= 4;
		wr(LPCAL_ADR_IRQ_MASK, 32'h0000_0000);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0011);
		wait_idle();
		rd_chk("ref xtal", LPCAL_ADR_REF_CNT, 32'h0000_01ff);
		lp_range("lpc xtal");
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		rd_chk("irq sta x", LPCAL_ADR_IRQ_STAT, 32'h0000_0001);
		// abort in mid-run holds the reference count
		wr(LPCAL_ADR_CONTROL, 32'h0000_0011);
		repeat (1000) @(posedge clk);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0010);
		rd_chk("sta abort", LPCAL_ADR_STATUS, 32'h0000_0000);
		wb(1'b0, LPCAL_ADR_REF_CNT, 32'h0000_0000, hold);
		repeat (200) @(posedge clk);
		rd_chk("ref stopped", LPCAL_ADR_REF_CNT, hold);
		chk("ref partial", {31'h0, hold != 32'h0 && hold < 32'h1ff}, 32'h0000_0001);
		// calibration reset in mid-run
		xsel <= 1'b0;
		lp_hp <= 16;
		wr(LPCAL_ADR_CONTROL, 32'h0000_0001);
		repeat (500) @(posedge clk);
		// a frozen block counts no oscillator edges
		wb(1'b0, LPCAL_ADR_REF_CNT, 32'h0000_0000, hold);
		clk_en <= 1'b0;
		repeat (300) @(posedge clk);
		clk_en <= 1'b1;
		wb(1'b0, LPCAL_ADR_REF_CNT, 32'h0000_0000, v);
		chk("ref frozen", {31'h0, (v - hold) <= 32'd2}, 32'h0000_0001);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0008);
		rd_chk("ctl rst", LPCAL_ADR_CONTROL, 32'h0000_0000);
		rd_chk("sta rst", LPCAL_ADR_STATUS, 32'h0000_0000);
		rd_chk("ref rst", LPCAL_ADR_REF_CNT, 32'h0000_0000);
		rd_chk("lpc rst", LPCAL_ADR_LP_CNT, 32'h0000_0000);
		// dead reference ends in a timeout, no done
		ref_hp <= 0;
		wr(LPCAL_ADR_IRQ_MASK, 32'h0000_0002);
		wr(LPCAL_ADR_CONTROL, 32'h0000_0001);
		wait_idle();
		rd_chk("sta tmo", LPCAL_ADR_STATUS, 32'h0000_0000);
		chk("irq tmo", {31'h0, irq}, 32'h0000_0001);
		rd_chk("irq sta tmo", LPCAL_ADR_IRQ_STAT, 32'h0000_0002);
		complete_run();
	end
endmodule
